//--- bstd_defs.vh
// Constants for the bit set and bit test skip decoder.
// Assumes a 12-bit instruction word and a 32-entry file register space.
//
// Contract
// - Opcode 0101 forces bit b of file register f to one, no flags touched.
// - Opcode 0110 tests bit b of f and skips the next instruction if zero.
// - Opcode 0111 tests bit b of f and skips the next instruction if one.
// - A taken skip flushes the prefetched word for a no-op second cycle.
`ifndef BSTD_DEFS_VH
`define BSTD_DEFS_VH

`define BSTD_OPC_HI       11
`define BSTD_OPC_LO       8
`define BSTD_BIT_HI       7
`define BSTD_BIT_LO       5
`define BSTD_ADR_HI       4
`define BSTD_ADR_LO       0

`define BSTD_OPC_SET      4'h5
`define BSTD_OPC_SKCLR    4'h6
`define BSTD_OPC_SKSET    4'h7

`endif

//--- bstd_decoder.v
// Bit set and bit test skip decoder for a small 8-bit core.
// Assumes the core gives one instruction per cycle with a valid strobe,
// and returns the addressed file register byte in the same cycle.
`default_nettype none
`include "bstd_defs.vh"

module bstd_decoder
#(
    parameter DATA_W = 8,
    parameter ADR_W  = 5
)
(
    input  wire              clk_sys_i,
    input  wire              rst_n_i,
    input  wire [11:0]       instr_i,
    input  wire              instr_valid_i,
    input  wire [DATA_W-1:0] file_rdata_i,
    output reg  [ADR_W-1:0]  file_addr_o,
    output reg  [DATA_W-1:0] file_wdata_o,
    output reg               file_we_o,
    output reg               flush_o,
    output reg               busy_o,
    output reg               hit_o
);

    // -------------------------------------------------------------
    // Local widths
    // -------------------------------------------------------------
    localparam BIDX_W = `BSTD_BIT_HI - `BSTD_BIT_LO + 1;
    localparam OPC_W  = `BSTD_OPC_HI - `BSTD_OPC_LO + 1;

    // -------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------
    // Mask with only the selected bit high
    function [DATA_W-1:0] bit_mask;
        input [BIDX_W-1:0] idx;
        integer n;
        begin
            bit_mask = {DATA_W{1'b0}};
            for (n = 0; n < DATA_W; n = n + 1)
            begin
                if (n == idx)
                begin
                    bit_mask[n] = 1'b1;
                end
            end
        end
    endfunction

    // Outcome of a test opcode
    function skip_taken;
        input on_clear;
        input on_set;
        input tested;
        begin
            skip_taken = (on_clear && !tested) || (on_set && tested);
        end
    endfunction

    // Opcode compare, gated by an executing slot
    function op_match;
        input [OPC_W-1:0] code;
        input [OPC_W-1:0] want;
        input             live;
        begin
            op_match = live && (code == want);
        end
    endfunction

    // -------------------------------------------------------------
    // Field extraction
    // -------------------------------------------------------------
    wire [OPC_W-1:0]  opc;
    wire [BIDX_W-1:0] bidx;
    wire [ADR_W-1:0]  fadr;

    assign opc  = instr_i[`BSTD_OPC_HI:`BSTD_OPC_LO];
    assign bidx = instr_i[`BSTD_BIT_HI:`BSTD_BIT_LO];
    assign fadr = instr_i[`BSTD_ADR_HI:`BSTD_ADR_LO];

    // -------------------------------------------------------------
    // Instruction classes
    // -------------------------------------------------------------
    wire go;
    wire is_set;
    wire is_skc;
    wire is_sks;
    wire sel_bit;
    wire skip;

    // A flushed slot runs as a no-op
    assign go      = instr_valid_i && !flush_o;
    assign is_set  = op_match(opc, `BSTD_OPC_SET, go);
    assign is_skc  = op_match(opc, `BSTD_OPC_SKCLR, go);
    assign is_sks  = op_match(opc, `BSTD_OPC_SKSET, go);
    assign sel_bit = file_rdata_i[bidx];
    assign skip    = skip_taken(is_skc, is_sks, sel_bit);

    // -------------------------------------------------------------
    // Next output values
    // -------------------------------------------------------------
    reg [ADR_W-1:0]  addr_nxt;
    reg [DATA_W-1:0] wdata_nxt;
    reg              we_nxt;
    reg              flush_nxt;
    reg              busy_nxt;
    reg              hit_nxt;

    // No status flags exist here, so none can change
    always @*
    begin
        addr_nxt  = fadr;
        wdata_nxt = file_rdata_i | bit_mask(bidx);
        we_nxt    = 1'b0;
        flush_nxt = 1'b0;
        busy_nxt  = 1'b0;
        hit_nxt   = 1'b0;
        case (opc)
            `BSTD_OPC_SET:
            begin
                we_nxt  = is_set;
                hit_nxt = is_set;
            end
            `BSTD_OPC_SKCLR,
            `BSTD_OPC_SKSET:
            begin
                hit_nxt   = is_skc || is_sks;
                flush_nxt = skip;
                busy_nxt  = skip;
            end
            default:
            begin
                we_nxt = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------
    // Write address follows the executing word
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            file_addr_o <= {ADR_W{1'b0}};
        end
        else
        begin
            file_addr_o <= addr_nxt;
        end
    end

    // Read byte with the chosen bit forced high
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            file_wdata_o <= {DATA_W{1'b0}};
        end
        else
        begin
            file_wdata_o <= wdata_nxt;
        end
    end

    // Write strobe, one cycle
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            file_we_o <= 1'b0;
        end
        else
        begin
            file_we_o <= we_nxt;
        end
    end

    // Discard of the prefetched word
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            flush_o <= 1'b0;
        end
        else
        begin
            flush_o <= flush_nxt;
        end
    end

    // Second cycle of a taken skip
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
        end
        else
        begin
            busy_o <= busy_nxt;
        end
    end

    // Executed a bit instruction last cycle
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            hit_o <= 1'b0;
        end
        else
        begin
            hit_o <= hit_nxt;
        end
    end

endmodule // bstd_decoder
`default_nettype wire

//--- bstd_regs.sv
// Partner: 32 file registers, read combinationally at the executing address.
`default_nettype none
module bstd_regs (input wire logic clk_sys_i, file_we_o,
    input wire logic [11:0] instr_i, input wire logic [4:0] file_addr_o,
    input wire logic [7:0] file_wdata_o, output logic [7:0] file_rdata_i);
    timeunit 1ns; timeprecision 1ps;
    logic [7:0] m [32];
    initial foreach (m[i]) m[i] = 8'(i * 37);
    assign file_rdata_i = m[instr_i[4:0]];
    always @(posedge clk_sys_i) if (file_we_o) m[file_addr_o] <= file_wdata_o;
endmodule // bstd_regs
`default_nettype wire

//--- bstd_decoder_chk.sv
// Checker for the bit decoder, bound to its ports.
`default_nettype none
module bstd_decoder_chk (input wire logic clk_sys_i, rst_n_i, instr_valid_i,
    flush_o, file_we_o, busy_o, hit_o, input wire logic [11:0] instr_i,
    input wire logic [7:0] file_rdata_i, file_wdata_o,
    input wire logic [4:0] file_addr_o);
    wire t = instr_valid_i && !flush_o;
    wire [3:0] op = instr_i[11:8];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_set_write: assert property (t && op == 4'h5 |=> file_we_o &&
        file_wdata_o == ($past(file_rdata_i) | 8'h01 << $past(instr_i[7:5])))
        else $error("bad set data");
    a_set_addr: assert property (t && op == 4'h5 |=>
        file_addr_o == $past(instr_i[4:0])) else $error("bad set address");
    a_skip_test: assert property (t && op[3:1] == 3'h3 |=>
        flush_o == ($past(file_rdata_i[instr_i[7:5]]) == $past(op[0])))
        else $error("bad skip decision");
    a_skip_nop: assert property (flush_o |=> !flush_o && !file_we_o)
        else $error("skip cycle not a no-op");
    a_other_quiet: assert property (!(t && op inside {[4'h5:4'h7]}) |=>
        !file_we_o && !flush_o) else $error("idle cycle acted");
    a_hit_pulse: assert property (t && op inside {[4'h5:4'h7]} |=>
        hit_o) else $error("bit instruction not flagged");
    a_busy_skip: assert property (t && op[3:1] == 3'h3 |=>
        busy_o == flush_o) else $error("busy not on skip cycle");
endmodule // bstd_decoder_chk
bind bstd_decoder bstd_decoder_chk u_chk (.*);
`default_nettype wire

//--- bstd_decoder_tb.sv
// Bench: random instructions with opcodes 4 to 8, outputs checked a cycle later.
`default_nettype none
module bstd_decoder_tb;
    timeunit 1ns; timeprecision 1ps;
    logic clk_sys_i = 0, rst_n_i = 0, instr_valid_i = 0, file_we_o, flush_o;
    logic busy_o, hit_o, t, ew, sk;
    logic [16:0] seen;
    logic [11:0] instr_i = 0;
    logic [7:0] file_rdata_i, file_wdata_o;
    logic [4:0] file_addr_o;
    logic [16:0] e = 0;
    int err_count, samples_checked, cyc;
    always #2.5 clk_sys_i = !clk_sys_i;
    bstd_regs u_bstd_regs (.*);
    bstd_decoder u_bstd_decoder (.*);
    task chk(logic [16:0] s, x);
        samples_checked++;
        if (s !== x) $display("ERROR outputs exp %h got %h", x, s);
        err_count += s !== x;
    endtask
    task results;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) if (++cyc > 2000) begin err_count++; results; end
    initial
    begin
        void'($urandom(32'h2134));
        repeat (20) @(negedge clk_sys_i);
        rst_n_i = 1;
        for (int i = 0; i < 400; i++)
        begin
            @(negedge clk_sys_i);
            seen = {hit_o, busy_o, file_we_o, flush_o,
                file_we_o ? {file_wdata_o, file_addr_o} : 13'h0};
            chk(seen, e);
            instr_valid_i = i < 6 || $urandom % 4 > 0;
            instr_i = i < 6 ? {4'h5 + 4'(i % 3), i[0] ? 8'hff : 8'h00}
                : {4'(4 + $urandom % 5), 8'($urandom)};
            #1 t = instr_valid_i && !e[13] && instr_i[11:8] inside {[5:7]};
            ew = t && instr_i[11:8] == 4'h5;
            sk = t && !ew && file_rdata_i[instr_i[7:5]] == instr_i[8];
            e = {t, sk, ew, sk, ew ?
                {file_rdata_i | 8'h01 << instr_i[7:5], instr_i[4:0]} : 13'h0};
        end
        results;
    end
endmodule // bstd_decoder_tb
`default_nettype wire
